/* File: rtl/pis_ctrl.sv */
`timescale 1ns/1ps
module pis_ctrl #(
  parameter int          TICK_CYCLES = pis_pkg::TICK_CYCLES,
  parameter logic [15:0] RATED_RST   = pis_pkg::RATED_RST
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  // AHB-Lite slave
  input  wire logic               i_hsel,
  input  wire logic [7:0]         i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic [31:0]             o_hrdata,
  output logic                    o_hreadyout,
  output logic                    o_hresp,
  // Process measurements
  input  wire pis_pkg::pis_meas_t i_meas,
  // Motor stage and display
  output logic [9:0]              o_demand,
  output logic                    o_motor_en,
  output logic                    o_standby_disp
);
  typedef enum logic [1:0] {S_IDLE, S_FB, S_INT} pis_state_t;

  pis_state_t             state;
  pis_pkg::pis_ctrl_t     ctrl;
  pis_pkg::pis_ctrl_t     next_ctrl;
  logic [8:0]             gain;
  logic [8:0]             itime;
  logic [9:0]             dsp;
  logic [7:0]             stby_time;
  logic [9:0]             wake;
  logic [15:0]            rated;
  logic [9:0]             minspd;
  logic                   wr_pend;
  logic [7:0]             wr_addr;
  logic [31:0]            rd;
  logic [31:0]            w_gain;
  logic [31:0]            w_itime;
  logic [31:0]            w_dsp;
  logic [31:0]            w_stby;
  logic [31:0]            w_wake;
  logic [31:0]            w_min;
  logic                   tick;
  logic                   cur_start;
  logic                   cur_done;
  logic [31:0]            cur_num;
  logic [31:0]            cur_den;
  logic [31:0]            cur_q;
  logic                   int_start;
  logic                   int_done;
  logic [31:0]            int_num;
  logic [31:0]            int_den;
  logic [31:0]            int_q;
  logic [31:0]            fb_raw;
  logic [31:0]            fb_lim;
  logic [9:0]             next_fb;
  logic [9:0]             fb;
  logic [9:0]             sp;
  logic signed [11:0]     next_err;
  logic signed [11:0]     err;
  logic signed [21:0]     ge;
  logic [21:0]            ge_mag;
  logic signed [21:0]     pterm;
  logic signed [21:0]     inc;
  logic signed [21:0]     u_raw;
  logic signed [21:0]     isum;
  logic signed [20:0]     integ;
  logic signed [20:0]     next_integ;
  logic                   hold;
  logic                   step;
  logic                   pi_mode;
  logic                   wake_now;
  logic                   at_min;
  logic                   standby;
  logic [15:0]            stby_cnt;
  logic [15:0]            stby_lim;

  function automatic logic [31:0] lim(input logic [31:0] v,
                                      input logic [31:0] mx);
    return (v > mx) ? mx : v;
  endfunction : lim

  function automatic logic [9:0] clamp(input logic signed [21:0] v,
                                       input logic [9:0] lo);
    if (v < $signed({12'h000, lo})) begin
      return lo;
    end else if (v > $signed({12'h000, pis_pkg::PCT_MAX})) begin
      return pis_pkg::PCT_MAX;
    end else begin
      return v[9:0];
    end
  endfunction : clamp

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
      wr_addr <= i_haddr;
    end
  end

  // Writes saturate at each setting's upper limit, except rated current, which takes the full 16 bits
  assign w_gain  = lim(32'(i_hwdata[8:0]), 32'(pis_pkg::GAIN_MAX));
  assign w_itime = lim(32'(i_hwdata[8:0]), 32'(pis_pkg::ITIME_MAX));
  assign w_dsp   = lim(32'(i_hwdata[9:0]), 32'(pis_pkg::PCT_MAX));
  assign w_stby  = lim(32'(i_hwdata[7:0]), 32'(pis_pkg::STBY_MAX));
  assign w_wake  = lim(32'(i_hwdata[9:0]), 32'(pis_pkg::PCT_MAX));
  assign w_min   = lim(32'(i_hwdata[9:0]), 32'(pis_pkg::PCT_MAX));

  always_comb begin
    next_ctrl = pis_pkg::pis_ctrl_t'(i_hwdata[pis_pkg::CTRL_W-1:0]);
    if (next_ctrl.fb_sel > pis_pkg::FB_MAX) begin
      next_ctrl.fb_sel = pis_pkg::FB_MAX;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl      <= '0;
      gain      <= pis_pkg::GAIN_RST;
      itime     <= pis_pkg::ITIME_RST;
      dsp       <= pis_pkg::DSP_RST;
      stby_time <= pis_pkg::STBY_RST;
      wake      <= pis_pkg::WAKE_RST;
      rated     <= RATED_RST;
      minspd    <= pis_pkg::MINSPD_RST;
    end else if (wr_pend) begin
      case (wr_addr)
        pis_pkg::OFS_CTRL:   ctrl      <= next_ctrl;
        pis_pkg::OFS_GAIN:   gain      <= w_gain[8:0];
        pis_pkg::OFS_ITIME:  itime     <= w_itime[8:0];
        pis_pkg::OFS_DSP:    dsp       <= w_dsp[9:0];
        pis_pkg::OFS_STBY:   stby_time <= w_stby[7:0];
        pis_pkg::OFS_WAKE:   wake      <= w_wake[9:0];
        pis_pkg::OFS_RATED:  rated     <= i_hwdata[15:0];
        pis_pkg::OFS_MINSPD: minspd    <= w_min[9:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (i_haddr)
      pis_pkg::OFS_CTRL:   rd = 32'(ctrl);
      pis_pkg::OFS_GAIN:   rd = 32'(gain);
      pis_pkg::OFS_ITIME:  rd = 32'(itime);
      pis_pkg::OFS_DSP:    rd = 32'(dsp);
      pis_pkg::OFS_STBY:   rd = 32'(stby_time);
      pis_pkg::OFS_WAKE:   rd = 32'(wake);
      pis_pkg::OFS_RATED:  rd = 32'(rated);
      pis_pkg::OFS_MINSPD: rd = 32'(minspd);
      pis_pkg::OFS_STATUS:
        rd = 32'({o_motor_en, standby, 6'h00, o_demand});
      pis_pkg::OFS_FB:     rd = 32'(fb);
      pis_pkg::OFS_ERR:    rd = {{20{err[11]}}, err};
      pis_pkg::OFS_AIN1:   rd = 32'(i_meas.ain1);
      pis_pkg::OFS_AIN2:   rd = 32'(i_meas.ain2);
      default:             rd = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_hrdata <= 32'h00000000;
    end else if (i_hsel & i_hready & i_htrans[1] & ~i_hwrite) begin
      o_hrdata <= rd;
    end else begin
      o_hrdata <= 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample tick and dividers
  pis_tick #(.N(TICK_CYCLES)) u_tick (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .o_tick  (tick)
  );

  assign cur_start = (state == S_IDLE) & tick;
  assign cur_num   = 32'(32'(i_meas.cur) * pis_pkg::CUR_SCALE);
  assign cur_den   = (rated == 16'h0000) ? 32'h00000001 : 32'(rated);

  pis_div #(.W(32)) u_cur_div (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_start (cur_start),
    .i_num   (cur_num),
    .i_den   (cur_den),
    .o_done  (cur_done),
    .o_quot  (cur_q)
  );

  assign int_start = (state == S_FB) & cur_done;
  assign ge        = 22'($signed({1'b0, gain}) * next_err);
  assign ge_mag    = ge[21] ? 22'(-ge) : ge;
  assign int_num   = 32'(ge_mag) << pis_pkg::INT_FRAC;
  assign int_den   = (itime == 9'h000) ? 32'h00000001 :
                     32'(32'(itime) * pis_pkg::ITIME_DEN_SCALE);

  pis_div #(.W(32)) u_int_div (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_start (int_start),
    .i_num   (int_num),
    .i_den   (int_den),
    .o_done  (int_done),
    .o_quot  (int_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Setpoint, feedback and error
  assign sp = ctrl.sp_sel ? i_meas.ain1 : dsp;

  always_comb begin
    unique case (ctrl.fb_sel)
      pis_pkg::FB_AIN2: fb_raw = 32'(i_meas.ain2);
      pis_pkg::FB_AIN1: fb_raw = 32'(i_meas.ain1);
      pis_pkg::FB_CUR:  fb_raw = cur_q;
      pis_pkg::FB_VBUS: fb_raw = 32'(i_meas.vbus);
      pis_pkg::FB_DIFF: fb_raw = (i_meas.ain1 > i_meas.ain2) ?
                          32'(i_meas.ain1 - i_meas.ain2) : 32'h0;
      pis_pkg::FB_MAX:  fb_raw = (i_meas.ain1 > i_meas.ain2) ?
                          32'(i_meas.ain1) : 32'(i_meas.ain2);
      default:          fb_raw = 32'(i_meas.ain2);
    endcase
  end

  assign fb_lim   = lim(fb_raw, 32'(pis_pkg::PCT_MAX));
  assign next_fb  = fb_lim[9:0];
  assign next_err = ctrl.mode[0] ?
                    $signed({2'b00, next_fb}) - $signed({2'b00, sp}) :
                    $signed({2'b00, sp}) - $signed({2'b00, next_fb});

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= S_IDLE;
      fb    <= 10'h000;
      err   <= 12'sh000;
    end else begin
      unique case (state)
        S_IDLE: if (tick) state <= S_FB;
        S_FB: if (cur_done) begin
          fb    <= next_fb;
          err   <= next_err;
          state <= S_INT;
        end
        S_INT: if (int_done) state <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PI regulator
  assign step  = (state == S_INT) & int_done;
  assign pterm = 22'($signed({1'b0, gain}) * err / pis_pkg::GAIN_DIV);
  assign inc   = (itime == 9'h000) ? 22'sh0 :
                 err[11] ? 22'(-$signed(22'(int_q))) : $signed(22'(int_q));
  assign u_raw = pterm + 22'(integ >>> pis_pkg::INT_FRAC);
  assign hold  = (u_raw > $signed({12'h000, pis_pkg::PCT_MAX}) && inc > 0) ||
                 (u_raw < $signed({12'h000, minspd}) && inc < 0);
  assign isum  = 22'(integ) + inc;

  always_comb begin
    if (hold) begin
      next_integ = integ;
    end else if (isum > 22'(pis_pkg::INT_FULL)) begin
      next_integ = pis_pkg::INT_FULL;
    end else if (isum < -22'(pis_pkg::INT_FULL)) begin
      next_integ = -pis_pkg::INT_FULL;
    end else begin
      next_integ = isum[20:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      integ    <= 21'sh0;
      o_demand <= 10'h000;
    end else if (!ctrl.run) begin
      integ    <= 21'sh0;
      o_demand <= 10'h000;
    end else if (step) begin
      if (wake_now && ctrl.mode[1]) begin
        integ    <= pis_pkg::INT_FULL;
        o_demand <= pis_pkg::PCT_MAX;
      end else if ((standby && !wake_now) || (!standby && at_min &&
                   stby_cnt + 16'h0001 >= stby_lim)) begin
        o_demand <= 10'h000;
      end else begin
        integ    <= next_integ;
        o_demand <= clamp(u_raw, minspd);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Standby
  assign pi_mode  = (ctrl.ctrl_src == pis_pkg::CSRC_PI_A) ||
                    (ctrl.ctrl_src == pis_pkg::CSRC_PI_B);
  assign wake_now = standby && (pi_mode ?
                    (err >= $signed({2'b00, wake})) : (err > 0));
  assign stby_lim = 16'(32'(stby_time) * pis_pkg::TICKS_PER_STBY_LSB);
  assign at_min   = (stby_time != 8'h00) && (o_demand <= minspd);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      standby  <= 1'b0;
      stby_cnt <= 16'h0000;
    end else if (!ctrl.run) begin
      standby  <= 1'b0;
      stby_cnt <= 16'h0000;
    end else if (step) begin
      if (standby) begin
        if (wake_now) standby <= 1'b0;
        stby_cnt <= 16'h0000;
      end else if (at_min) begin
        if (stby_cnt + 16'h0001 >= stby_lim) begin
          standby  <= 1'b1;
          stby_cnt <= 16'h0000;
        end else begin
          stby_cnt <= stby_cnt + 16'h0001;
        end
      end else begin
        stby_cnt <= 16'h0000;
      end
    end
  end

  assign o_motor_en     = ctrl.run & ~standby;
  assign o_standby_disp = standby;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_out_rng;
    o_demand <= pis_pkg::PCT_MAX;
  endproperty
  a_out_rng: assert property (p_out_rng)
    else $error("demand above 100 percent");

  property p_stby_out;
    standby |-> !o_motor_en && o_demand == 10'h000 && o_standby_disp;
  endproperty
  a_stby_out: assert property (p_stby_out)
    else $error("motor active in standby");

  property p_stby_en;
    $rose(standby) |-> $past(stby_time) != 8'h00 &&
                       $past(o_demand) <= $past(minspd);
  endproperty
  a_stby_en: assert property (p_stby_en)
    else $error("standby entered while disabled or above minimum");

  property p_wake_full;
    $fell(standby) && $past(ctrl.run) && ctrl.run && $past(ctrl.mode[1])
      |-> o_demand == pis_pkg::PCT_MAX;
  endproperty
  a_wake_full: assert property (p_wake_full)
    else $error("wake did not force full output");

  property p_wake_lvl;
    $fell(standby) && ctrl.run && $past(ctrl.run) && $past(pi_mode)
      |-> $past(err) >= $signed({2'b00, $past(wake)});
  endproperty
  a_wake_lvl: assert property (p_wake_lvl)
    else $error("woke below error level");

  property p_fb_diff;
    state == S_FB && cur_done && ctrl.fb_sel == pis_pkg::FB_DIFF |=>
      fb == (($past(i_meas.ain1) > $past(i_meas.ain2)) ?
             $past(i_meas.ain1) - $past(i_meas.ain2) : 10'h000);
  endproperty
  a_fb_diff: assert property (p_fb_diff)
    else $error("difference feedback wrong");

  property p_fb_max;
    state == S_FB && cur_done && ctrl.fb_sel == pis_pkg::FB_MAX |=>
      fb >= $past(i_meas.ain1) && fb >= $past(i_meas.ain2);
  endproperty
  a_fb_max: assert property (p_fb_max)
    else $error("largest feedback wrong");

  property p_fb_vbus;
    state == S_FB && cur_done && ctrl.fb_sel == pis_pkg::FB_VBUS |=>
      fb == (($past(i_meas.vbus) > 11'h3E8) ? 10'h3E8 :
             $past(i_meas.vbus[9:0]));
  endproperty
  a_fb_vbus: assert property (p_fb_vbus)
    else $error("bus voltage feedback wrong");

  property p_err_dir;
    state == S_FB && cur_done |=> err == ($past(ctrl.mode[0]) ?
      $signed({2'b00, fb}) - $signed({2'b00, $past(sp)}) :
      $signed({2'b00, $past(sp)}) - $signed({2'b00, fb}));
  endproperty
  a_err_dir: assert property (p_err_dir)
    else $error("error direction wrong");

  property p_sp_ain1;
    state == S_FB && cur_done && ctrl.sp_sel && !ctrl.mode[0] |=>
      err == $signed({2'b00, $past(i_meas.ain1)}) - $signed({2'b00, fb});
  endproperty
  a_sp_ain1: assert property (p_sp_ain1)
    else $error("analog setpoint not used");

  property p_gain;
    gain <= pis_pkg::GAIN_MAX;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain above limit");

  property p_itime;
    itime <= pis_pkg::ITIME_MAX;
  endproperty
  a_itime: assert property (p_itime)
    else $error("integral time above limit");

  c_stby: cover property ($rose(standby));
  c_wake: cover property ($fell(standby) && ctrl.run && ctrl.mode[1]);
  c_clamp: cover property (step && hold);
endmodule : pis_ctrl

/* File: include/pis_pkg.sv */
package pis_pkg;
  // Operation
  // - Proportional gain 0.0 to 30.0, default 1.0
  // - Integral time 0.0 to 30.0 s, default 1.0
  // - Modes 0,2 direct; modes 1,3 inverse action
  // - Modes 2,3: output 100% on standby wake
  // - Setpoint select: 0 digital, 1 analog input 1
  // - Digital setpoint 0 to 100.0%, default 0.0
  // - Feedback 0 analog input 2, 1 input 1
  // - Feedback 2: motor current percent of rated
  // - Feedback 3: bus 0-1000 V to 0-100%
  // - Feedback 4: input 1 minus 2, floor zero
  // - Feedback 5: larger of both analog inputs
  // - Standby after timed minimum speed; zero disables
  // - Standby disables motor output, shows indication
  // - PI mode standby wake at error level

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int TICK_TIME_US       = 1000;
  localparam int TICK_CYCLES        = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int STBY_LSB_MS        = 100;
  localparam int TICKS_PER_STBY_LSB = STBY_LSB_MS * 1000 / TICK_TIME_US;
  localparam int ITIME_LSB_MS       = 100;
  localparam int GAIN_DIV           = 10;
  localparam int ITIME_DEN_SCALE    =
    GAIN_DIV * ITIME_LSB_MS * 1000 / TICK_TIME_US;
  localparam int CUR_SCALE          = 1000;
  localparam int INT_FRAC           = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Limits and reset values (percent in 0.1 % steps)
  localparam logic [9:0]  PCT_MAX    = 10'h3E8;
  localparam logic [8:0]  GAIN_MAX   = 9'h12C;
  localparam logic [8:0]  GAIN_RST   = 9'h00A;
  localparam logic [8:0]  ITIME_MAX  = 9'h12C;
  localparam logic [8:0]  ITIME_RST  = 9'h00A;
  localparam logic [9:0]  DSP_RST    = 10'h000;
  localparam logic [7:0]  STBY_MAX   = 8'hFA;
  localparam logic [7:0]  STBY_RST   = 8'h00;
  localparam logic [9:0]  WAKE_RST   = 10'h032;
  localparam logic [9:0]  MINSPD_RST = 10'h000;
  localparam logic [15:0] RATED_RST  = 16'h0064;
  localparam logic signed [20:0] INT_FULL = 21'sh3E800;
  localparam logic [3:0]  CSRC_PI_A  = 4'h5;
  localparam logic [3:0]  CSRC_PI_B  = 4'h6;
  localparam int          CTRL_W     = 11;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_GAIN   = 8'h04;
  localparam logic [7:0] OFS_ITIME  = 8'h08;
  localparam logic [7:0] OFS_DSP    = 8'h0C;
  localparam logic [7:0] OFS_STBY   = 8'h10;
  localparam logic [7:0] OFS_WAKE   = 8'h14;
  localparam logic [7:0] OFS_RATED  = 8'h18;
  localparam logic [7:0] OFS_MINSPD = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_FB     = 8'h24;
  localparam logic [7:0] OFS_ERR    = 8'h28;
  localparam logic [7:0] OFS_AIN1   = 8'h2C;
  localparam logic [7:0] OFS_AIN2   = 8'h30;

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    FB_AIN2, FB_AIN1, FB_CUR, FB_VBUS, FB_DIFF, FB_MAX
  } pis_fb_t;

  typedef struct packed {
    logic       run;
    logic [3:0] ctrl_src;
    pis_fb_t    fb_sel;
    logic       sp_sel;
    logic [1:0] mode;
  } pis_ctrl_t;

  typedef struct packed {
    logic [9:0]  ain1;
    logic [9:0]  ain2;
    logic [15:0] cur;
    logic [10:0] vbus;
  } pis_meas_t;
endpackage : pis_pkg

/* File: rtl/pis_tick.sv */
`timescale 1ns/1ps
module pis_tick #(
  parameter int N = 100000
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Enable pulse
  output logic      o_tick
);
  localparam int CW = $clog2(N);
  logic [CW-1:0] cnt;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else if (cnt == CW'(N - 1)) begin
      cnt    <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : pis_tick

/* File: rtl/pis_div.sv */
`timescale 1ns/1ps
module pis_div #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // Request
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_num,
  input  wire logic [W-1:0] i_den,
  // Result
  output logic              o_done,
  output logic [W-1:0]      o_quot
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0]  rem;
  logic [W-1:0]  den;
  logic [CW-1:0] cnt;
  logic          busy;
  logic [W:0]    sh;
  logic [W:0]    df;

  always_comb begin
    sh = {rem, o_quot[W-1]};
    df = sh - {1'b0, den};
  end

  // Restoring divide, one quotient bit per cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rem    <= '0;
      den    <= '0;
      cnt    <= '0;
      busy   <= 1'b0;
      o_done <= 1'b0;
      o_quot <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        rem    <= '0;
        den    <= i_den;
        o_quot <= i_num;
        cnt    <= CW'(W);
        busy   <= 1'b1;
      end else if (busy) begin
        if (!df[W]) begin
          rem    <= df[W-1:0];
          o_quot <= {o_quot[W-2:0], 1'b1};
        end else begin
          rem    <= sh[W-1:0];
          o_quot <= {o_quot[W-2:0], 1'b0};
        end
        cnt <= cnt - 1'b1;
        if (cnt == CW'(1)) begin
          busy   <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule : pis_div

/* File: verif/pis_plant_model.sv */
`timescale 1ns/1ps
module pis_plant_model (
  // Clock and output stage
  input  wire logic          i_clk,
  input  wire logic          i_motor_en,
  // Process levels
  input  wire logic [9:0]    i_ain1,
  input  wire logic [9:0]    i_ain2,
  input  wire logic [15:0]   i_cur,
  input  wire logic [10:0]   i_vbus,
  // Sampled measurements
  output pis_pkg::pis_meas_t o_meas
);
  // No current flows while the output stage is off
  always_ff @(posedge i_clk) begin
    o_meas <= '{i_ain1, i_ain2, i_motor_en ? i_cur : 16'h0000, i_vbus};
  end
endmodule : pis_plant_model

/* File: verif/pis_ctrl_tb_top.sv */
`timescale 1ns/1ps
module pis_ctrl_tb_top;
  localparam int TK = 100;
  logic               i_clk, i_reset, hsel, hwrite, hready, hresp, rdy_q;
  logic               motor_en, sb;
  logic [7:0]         haddr;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        hwdata, hrdata, hr_q;
  logic [9:0]         demand, ain1, ain2;
  logic [15:0]        cur;
  logic [10:0]        vbus;
  pis_pkg::pis_meas_t meas;
  int                 num_errors, cmp_count;

  pis_ctrl #(.TICK_CYCLES(TK)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_meas(meas),
    .o_demand(demand), .o_motor_en(motor_en), .o_standby_disp(sb));
  pis_plant_model u_plant (
    .i_clk(i_clk), .i_motor_en(motor_en), .i_ain1(ain1), .i_ain2(ain2),
    .i_cur(cur), .i_vbus(vbus), .o_meas(meas));

  // Bus answer as seen before each edge
  always @(posedge i_clk) begin
    rdy_q <= hready;
    hr_q  <= hrdata;
  end

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (rdy_q !== 1'b1 && n < 20);
    if (rdy_q !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
  endtask : wait_rdy

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize  <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hr_q;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(a, 1'b1, d, rd);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(a, 1'b0, 32'h0, rd);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdc

  function automatic logic [31:0] ctl(input logic [2:0] fb, input logic sp,
                                      input logic [1:0] m, input logic [3:0] s);
    return {21'h0, 1'b1, s, fb, sp, m};
  endfunction : ctl

  task automatic ticks(input int n);
    repeat (n * TK + 100) @(posedge i_clk);
    #1;
  endtask : ticks

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({31'h0, motor_en}, 32'h0);
    rdc(8'h04, 32'h00A);
    rdc(8'h08, 32'h00A);
    rdc(8'h0C, 32'h000);
    rdc(8'h10, 32'h000);
    rdc(8'h14, 32'h032);
    rdc(8'h3C, 32'h000);
    wr(8'h04, 32'h1FF);
    rdc(8'h04, 32'h12C);
    wr(8'h10, 32'h0FF);
    rdc(8'h10, 32'h0FA);
    wr(8'h10, 32'h000);
  endtask : t_reset

  task automatic t_fb();
    logic [31:0] exp [6] = '{32'h0FA, 32'h258, 32'h1F4, 32'h2BC,
                             32'h15E, 32'h258};
    for (int s = 0; s < 6; s++) begin
      wr(8'h00, ctl(s[2:0], 1'b0, 2'h0, 4'h0));
      ticks(1);
      rdc(8'h24, exp[s]);
    end
    ain1 <= 10'h0C8;
    wr(8'h00, ctl(3'h4, 1'b0, 2'h0, 4'h0));
    ticks(1);
    rdc(8'h24, 32'h000);
    ain1 <= 10'h258;
    wr(8'h18, 32'h0C8);
    wr(8'h00, ctl(3'h2, 1'b0, 2'h0, 4'h0));
    ticks(1);
    rdc(8'h24, 32'h0FA);
    wr(8'h18, 32'h064);
    rdc(8'h2C, 32'h258);
    rdc(8'h30, 32'h0FA);
  endtask : t_fb

  task automatic t_pi();
    wr(8'h04, 32'h00A);
    wr(8'h08, 32'h000);
    wr(8'h0C, 32'h1F4);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, ctl(3'h0, 1'b0, m[1:0], 4'h0));
      ticks(2);
      chk({22'h0, demand}, m[0] ? 32'h0 : 32'h0FA);
    end
    wr(8'h1C, 32'h064);
    ticks(2);
    chk({22'h0, demand}, 32'h064);
    rdc(8'h28, 32'hFFFFFF06);
    wr(8'h1C, 32'h000);
    wr(8'h00, ctl(3'h0, 1'b1, 2'h0, 4'h0));
    ticks(2);
    chk({22'h0, demand}, 32'h15E);
    wr(8'h04, 32'h014);
    wr(8'h00, ctl(3'h0, 1'b0, 2'h0, 4'h0));
    ticks(2);
    chk({22'h0, demand}, 32'h1F4);
    wr(8'h04, 32'h00A);
    wr(8'h08, 32'h00A);
    ticks(20);
    chk({31'h0, demand > 10'h0FA}, 32'h1);
  endtask : t_pi

  task automatic t_sb();
    int n;
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h00, ctl(3'h0, 1'b0, 2'h2, 4'h5));
    wr(8'h10, 32'h001);
    ticks(50);
    chk({31'h0, sb}, 32'h0);
    ticks(60);
    chk({31'h0, sb}, 32'h1);
    rdc(8'h20, 32'h10000);
    wr(8'h0C, 32'h122);
    ticks(3);
    chk({31'h0, sb}, 32'h1);
    wr(8'h0C, 32'h190);
    for (n = 0; n < 400 && sb !== 1'b0; n++) begin
      @(posedge i_clk);
      #1;
    end
    chk({31'h0, sb}, 32'h0);
    chk({22'h0, demand}, 32'h3E8);
    chk({31'h0, motor_en}, 32'h1);
  endtask : t_sb

  initial begin
    i_reset = 1'b1;
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    ain1 = 10'h258;
    ain2 = 10'h0FA;
    cur  = 16'h0032;
    vbus = 11'h2BC;
    num_errors = 0;
    cmp_count  = 0;
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_fb();
    t_pi();
    t_sb();
    print_verdict();
  end
endmodule : pis_ctrl_tb_top
